/* common/daof_pkg.sv */
/*
  shared constants and carrier types of the dual converter output formatter.
  assumes a 25 MHz system clock and a core that hands one sample per channel.
  // Function
  // RULE_01 - encode clock stopped or slower than 500kHz puts the device into nap.
  // RULE_02 - with stabilizer on, 30-70% encode duty gives a steady 50% internal clock.
  // RULE_03 - after an encode frequency change, stabilizer needs 100 cycles to relock.
  // RULE_04 - stabilizer enable comes from clock mode register, or chip-select strap.
  // RULE_05 - controller keeps stabilizer off below 5Msps and for fast rate changes.
  // RULE_06 - output mode from register, or serial clock strap; DDR CMOS register only.
  // RULE_07 - full rate CMOS: sixteen bits per channel, own overflow, forwarded clock.
  // RULE_08 - DDR CMOS multiplexes two bits per pin, seventeen fewer output lines.
  // RULE_09 - DDR LVDS: eight data pairs per channel, one overflow, one clock pair.
  // RULE_10 - DDR: even bit while output clock low, odd bit while it is high.
  // RULE_11 - DDR modes merge both channel overflow flags onto one shared output.
  // RULE_12 - shared overflow shows channel two while clock low, channel one high.
  // RULE_13 - LVDS current defaults 3.5mA, selectable 1.75mA up to 4.5mA.
  // RULE_14 - internal termination on doubles the selected LVDS driver current.
  // RULE_15 - overflow high on over or under range, same latency as data.
  // RULE_16 - full rate: data changes at forwarded clock fall, receiver samples rise.
  // RULE_17 - DDR modes: data changes at both forwarded clock edges.
  // RULE_18 - forwarded clock can be delayed 0, 45, 90 or 135 degrees.
  // RULE_19 - controller enables stabilizer before any nonzero clock phase shift.
  // RULE_20 - separate bit inverts forwarded clock, giving 45 to 315 degrees.
  // RULE_21 - offset binary default; two's complement inverts the top bit.
  // RULE_22 - mid-scale 8000; over-range saturates ones, under-range zeros, flag set.
  // RULE_23 - both DDR halves of one clock period come from the same conversion.
*/
package daof_pkg;
    localparam int SAMPLE_W = 16;
    localparam int DDR_W = SAMPLE_W / 2;
    localparam int CNT_W = 8;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int DLY_DEPTH = 32;
    localparam int CUR_W = 10;
    // timing, nap threshold as a longest period, rounded down
    localparam int CLK_PERIOD_NS = 40;
    localparam int NAP_FREQ_KHZ = 500;
    localparam int NAP_PERIOD_NS = 1000000 / NAP_FREQ_KHZ;
    localparam int NAP_CYCLES = NAP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LOCK_ENC_CYCLES = 100;
    localparam int DUTY_MIN_PCT = 30;
    localparam int DUTY_MAX_PCT = 70;
    localparam int PCT_FULL = 100;
    localparam int PHASE_STEPS_LOG2 = 3;
    // register map
    localparam logic [ADDR_W-1:0] ADDR_CLKMODE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OUTMODE = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_FORMAT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] CLKMODE_RST = 4'h0;
    localparam logic [5:0] OUTMODE_RST = 6'h10;
    localparam logic FORMAT_RST = 1'b0;
    // sample codes
    localparam logic [SAMPLE_W-1:0] CODE_ONES = 16'hffff;
    localparam logic [SAMPLE_W-1:0] CODE_ZEROS = 16'h0000;
    localparam logic [SAMPLE_W-1:0] CODE_MID = 16'h8000;
    // lvds current in 10 uA units, code 7 falls back to the default
    localparam logic [2:0] LVDS_CUR_DEFAULT = 3'h4;
    localparam logic [CUR_W-1:0] LVDS_CUR_TBL [0:7] = '{10'h0af, 10'h0d2, 10'h0fa, 10'h12c,
        10'h15e, 10'h190, 10'h1c2, 10'h15e};

    typedef enum logic [1:0] {
        MODE_FULL_CMOS = 2'b00,
        MODE_DDR_CMOS = 2'b01,
        MODE_DDR_LVDS = 2'b10
    } daof_mode_t;

    typedef struct packed {
        logic invert;
        logic [1:0] phase;
        logic dcsEn;
    } daof_clkmode_t;

    typedef struct packed {
        logic term;
        logic [2:0] current;
        logic [1:0] mode;
    } daof_outmode_t;

    typedef struct packed {
        logic overRange;
        logic underRange;
        logic [SAMPLE_W-1:0] code;
    } daof_sample_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] chanOneData;
        logic [SAMPLE_W-1:0] chanTwoData;
        logic chanOneOverrange;
        logic chanTwoOverrange;
        logic [DDR_W-1:0] chanOneDdrPin;
        logic [DDR_W-1:0] chanTwoDdrPin;
        logic sharedOverrangeOut;
    } daof_pins_t;
endpackage

/* design/daof_sync.sv */
/*
  three stage synchroniser for pin inputs, one lane per bit.
  assumes asynchronous inputs; output moves once stages two and three agree.
*/
`timescale 1ns/100ps
module daof_sync #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);
    logic [W-1:0] stageOne_r;
    logic [W-1:0] stageTwo_r;
    logic [W-1:0] stageThree_r;

    ////////////////////////////////////////////////////////////////////////
    // per bit chain and agreement filter
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    stageOne_r[i] <= 1'b0;
                    stageTwo_r[i] <= 1'b0;
                    stageThree_r[i] <= 1'b0;
                    synced[i] <= 1'b0;
                end
                else
                begin
                    stageOne_r[i] <= async[i];
                    stageTwo_r[i] <= stageOne_r[i];
                    stageThree_r[i] <= stageTwo_r[i];
                    if (stageTwo_r[i] == stageThree_r[i])
                        synced[i] <= stageThree_r[i];
                end
            end
        end
    endgenerate
endmodule

/* design/daof_top.sv */
/*
  output formatter of a two channel 16-bit converter: encode clock watch,
  duty cycle stabilizer, sample coding, full rate or DDR output and forwarded clock.
  assumes the encode clock and straps arrive as pins; core samples on clk.
*/
`timescale 1ns/100ps
module daof_top
    import daof_pkg::*;
#(
    parameter int NAP_CNT_P = NAP_CYCLES,
    parameter int LOCK_CNT_P = LOCK_ENC_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic encodeClockPos,
    input wire logic parallelMode,
    input wire logic chipSelectStrap,
    input wire logic serialClockStrap,
    input daof_pkg::daof_sample_t coreSampleOne,
    input daof_pkg::daof_sample_t coreSampleTwo,
    input wire logic [daof_pkg::ADDR_W-1:0] regAddr,
    input wire logic [daof_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [daof_pkg::DATA_W-1:0] regRdData,
    output daof_pkg::daof_pins_t pins,
    output logic forwardedClockPos,
    output logic forwardedClockNeg,
    output logic lvdsEnable,
    output logic lvdsTermEnable,
    output logic [daof_pkg::CUR_W-1:0] lvdsDriveCurrent,
    output logic napActive,
    output logic internalClockValid
);
    import daof_pkg::*;

    localparam logic [CNT_W-1:0] NAP_CNT = CNT_W'(NAP_CNT_P);
    localparam logic [6:0] LOCK_CNT = 7'(LOCK_CNT_P);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    logic [3:0] syncIn;
    logic encS;
    logic parS;
    logic csS;
    logic sckS;
    logic encPrev_r;
    logic encRise;
    logic encFall;
    logic [CNT_W-1:0] sinceRise_r;
    logic [CNT_W-1:0] sinceNxt;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] high_r;
    logic [CNT_W-1:0] measPeriod;
    logic [6:0] lockCnt_r;
    logic locked;
    logic dutyOk_r;
    logic napActive_r;
    logic icl_r;
    logic icl_nxt;
    logic iclRise;
    logic iclFall;
    logic [DLY_DEPTH-1:0] dly_r;
    logic [9:0] dlyProd;
    logic [4:0] dlyTap;
    logic fwdBase;
    logic fwd_r;
    daof_clkmode_t clkMode_r;
    daof_outmode_t outMode_r;
    logic twosComp_r;
    logic dcsEn;
    logic [1:0] phaseSel;
    logic clkInvert;
    daof_mode_t mode;
    logic [2:0] curSel;
    logic termSel;
    daof_sample_t fmtOne;
    daof_sample_t fmtTwo;
    logic [SAMPLE_W-1:0] holdOne_r;
    logic [SAMPLE_W-1:0] holdTwo_r;
    logic holdOfOne_r;
    logic [DDR_W-1:0] evenOne;
    logic [DDR_W-1:0] oddOne;
    logic [DDR_W-1:0] evenTwo;
    logic [DDR_W-1:0] oddTwo;
    logic [7:0] statusWord;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    daof_sync #(.W(4)) u_sync (
        .clk(clk),
        .srst(srst),
        .async({encodeClockPos, parallelMode, chipSelectStrap, serialClockStrap}),
        .synced(syncIn)
    );
    assign {encS, parS, csS, sckS} = syncIn;

    ////////////////////////////////////////////////////////////////////////
    // encode clock edges and period measurement
    assign encRise = encS & ~encPrev_r;
    assign encFall = ~encS & encPrev_r;
    assign measPeriod = (sinceRise_r == CNT_MAX) ? CNT_MAX : CNT_W'(sinceRise_r + 1'b1);
    assign sinceNxt = encRise ? '0 : measPeriod;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            encPrev_r <= 1'b0;
            sinceRise_r <= CNT_MAX;
            period_r <= '0;
            high_r <= '0;
        end
        else
        begin
            encPrev_r <= encS;
            sinceRise_r <= sinceNxt;
            if (encRise)
                period_r <= measPeriod;
            if (encFall)
                high_r <= measPeriod;
        end
    end

    // nap once no rising edge seen for the slow threshold
    always_ff @(posedge clk)
    begin
        if (srst)
            napActive_r <= 1'b1;
        else
            napActive_r <= (sinceNxt >= NAP_CNT); // RULE_01
    end

    // relock count in encode cycles, restarts on a period change
    always_ff @(posedge clk)
    begin
        if (srst)
            lockCnt_r <= '0;
        else if (napActive_r)
            lockCnt_r <= '0;
        else if (encRise)
        begin
            if (measPeriod != period_r)
                lockCnt_r <= '0; // RULE_03
            else if (lockCnt_r != LOCK_CNT)
                lockCnt_r <= 7'(lockCnt_r + 1'b1);
        end
    end
    assign locked = (lockCnt_r == LOCK_CNT);

    // encode duty window check, 30 to 70 percent
    always_ff @(posedge clk)
    begin
        if (srst)
            dutyOk_r <= 1'b0;
        else if (encRise)
            dutyOk_r <= (16'(high_r) * 16'(PCT_FULL) >= 16'(measPeriod) * 16'(DUTY_MIN_PCT))
                && (16'(high_r) * 16'(PCT_FULL) <= 16'(measPeriod) * 16'(DUTY_MAX_PCT));
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            clkMode_r <= CLKMODE_RST;
            outMode_r <= OUTMODE_RST; // RULE_13
            twosComp_r <= FORMAT_RST;
        end
        else if (regWr)
        begin
            case (regAddr)
                ADDR_CLKMODE: clkMode_r <= regWrData[3:0];
                ADDR_OUTMODE: outMode_r <= regWrData[5:0];
                ADDR_FORMAT: twosComp_r <= regWrData[0];
                default: ;
            endcase
        end
    end

    assign statusWord = {4'h0, internalClockValid, dutyOk_r, locked, napActive_r};

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (srst)
            regRdData <= '0;
        else if (regRd)
        begin
            case (regAddr)
                ADDR_CLKMODE: regRdData <= {4'h0, clkMode_r};
                ADDR_OUTMODE: regRdData <= {2'h0, outMode_r};
                ADDR_FORMAT: regRdData <= {7'h00, twosComp_r};
                ADDR_STATUS: regRdData <= statusWord;
                default: regRdData <= '0;
            endcase
        end
        else
            regRdData <= '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // effective settings: chip-select strap or fixed defaults in parallel mode, registers otherwise
    assign dcsEn = parS ? csS : clkMode_r.dcsEn; // RULE_04
    assign phaseSel = parS ? 2'h0 : clkMode_r.phase;
    assign clkInvert = parS ? 1'b0 : clkMode_r.invert;
    assign curSel = parS ? LVDS_CUR_DEFAULT : outMode_r.current;
    assign termSel = parS ? 1'b0 : outMode_r.term;

    // mode decode, DDR CMOS reachable through the register only
    always_comb
    begin
        mode = MODE_FULL_CMOS;
        if (parS)
            mode = sckS ? MODE_DDR_LVDS : MODE_FULL_CMOS; // RULE_06
        else
        begin
            case (outMode_r.mode)
                2'b01: mode = MODE_DDR_CMOS;
                2'b10: mode = MODE_DDR_LVDS;
                default: mode = MODE_FULL_CMOS;
            endcase
        end
    end

    // lvds driver settings, doubled current with internal termination
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            lvdsEnable <= 1'b0;
            lvdsTermEnable <= 1'b0;
            lvdsDriveCurrent <= LVDS_CUR_TBL[LVDS_CUR_DEFAULT];
        end
        else
        begin
            lvdsEnable <= (mode == MODE_DDR_LVDS); // RULE_09
            lvdsTermEnable <= termSel;
            lvdsDriveCurrent <= termSel ? CUR_W'({LVDS_CUR_TBL[curSel], 1'b0})
                : LVDS_CUR_TBL[curSel]; // RULE_13 RULE_14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal clock: regenerated 50% with stabilizer, raw encode otherwise
    always_comb
    begin
        icl_nxt = 1'b0;
        if (napActive_r)
            icl_nxt = 1'b0;
        else if (dcsEn)
            icl_nxt = (sinceNxt < (period_r >> 1)); // RULE_02
        else
            icl_nxt = encS;
    end
    assign iclRise = icl_nxt & ~icl_r;
    assign iclFall = ~icl_nxt & icl_r;

    always_ff @(posedge clk)
    begin
        if (srst)
            icl_r <= 1'b0;
        else
            icl_r <= icl_nxt;
    end

    assign internalClockValid = ~napActive_r & (~dcsEn | locked); // RULE_03

    ////////////////////////////////////////////////////////////////////////
    // sample coding: saturation, overflow flag, optional two's complement
    function automatic daof_sample_t fmtCode(input daof_sample_t s, input logic twos);
        daof_sample_t r;
        r.overRange = s.overRange;
        r.underRange = s.underRange;
        if (s.overRange)
            r.code = CODE_ONES; // RULE_22
        else if (s.underRange)
            r.code = CODE_ZEROS;
        else
            r.code = s.code;
        r.code = r.code ^ (twos ? CODE_MID : CODE_ZEROS); // RULE_21
        return r;
    endfunction

    assign fmtOne = fmtCode(coreSampleOne, twosComp_r);
    assign fmtTwo = fmtCode(coreSampleTwo, twosComp_r);

    // even bit lanes of the incoming conversion, odd bit lanes of the held conversion
    genvar i;
    generate
        for (i = 0; i < DDR_W; i++)
        begin : g_split
            assign evenOne[i] = fmtOne.code[2*i];
            assign evenTwo[i] = fmtTwo.code[2*i];
            assign oddOne[i] = holdOne_r[2*i+1];
            assign oddTwo[i] = holdTwo_r[2*i+1];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // hold of the conversion launched at the internal clock rise
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            holdOne_r <= CODE_ZEROS;
            holdTwo_r <= CODE_ZEROS;
            holdOfOne_r <= 1'b0;
        end
        else if (iclRise)
        begin
            holdOne_r <= fmtOne.code; // RULE_23
            holdTwo_r <= fmtTwo.code;
            holdOfOne_r <= fmtOne.overRange | fmtOne.underRange;
        end
    end

    // output pins, launched at internal clock edges
    always_ff @(posedge clk)
    begin
        if (srst)
            pins <= '0;
        else if (mode == MODE_FULL_CMOS)
        begin
            pins.chanOneDdrPin <= '0;
            pins.chanTwoDdrPin <= '0;
            pins.sharedOverrangeOut <= 1'b0;
            if (iclRise)
            begin
                pins.chanOneData <= fmtOne.code; // RULE_07 RULE_16
                pins.chanTwoData <= fmtTwo.code;
                pins.chanOneOverrange <= fmtOne.overRange | fmtOne.underRange; // RULE_15
                pins.chanTwoOverrange <= fmtTwo.overRange | fmtTwo.underRange;
            end
        end
        else
        begin
            pins.chanOneData <= '0;
            pins.chanTwoData <= '0;
            pins.chanOneOverrange <= 1'b0;
            pins.chanTwoOverrange <= 1'b0;
            if (iclRise)
            begin
                pins.chanOneDdrPin <= evenOne; // RULE_08 RULE_10 RULE_17
                pins.chanTwoDdrPin <= evenTwo;
                pins.sharedOverrangeOut <= fmtTwo.overRange | fmtTwo.underRange; // RULE_11
            end
            else if (iclFall)
            begin
                pins.chanOneDdrPin <= oddOne; // RULE_10 RULE_17
                pins.chanTwoDdrPin <= oddTwo;
                pins.sharedOverrangeOut <= holdOfOne_r; // RULE_12
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // forwarded clock: low while even half shows, delayed by phase eighths
    assign fwdBase = ~icl_nxt;
    assign dlyProd = 10'(phaseSel) * 10'(period_r);
    assign dlyTap = (dlyProd >> PHASE_STEPS_LOG2) > 10'(DLY_DEPTH - 1) ? 5'(DLY_DEPTH - 1)
        : 5'(dlyProd >> PHASE_STEPS_LOG2);

    always_ff @(posedge clk)
    begin
        if (srst)
            dly_r <= '1;
        else
            dly_r <= {dly_r[DLY_DEPTH-2:0], fwdBase};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            fwd_r <= 1'b1;
        else if (dlyTap == 5'h00)
            fwd_r <= fwdBase ^ clkInvert; // RULE_20
        else
            fwd_r <= dly_r[5'(dlyTap - 1'b1)] ^ clkInvert; // RULE_18 RULE_20
    end

    assign forwardedClockPos = fwd_r;
    assign forwardedClockNeg = ~fwd_r;
    assign napActive = napActive_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_nap_entry: assert property ( // RULE_01
        (sinceRise_r == NAP_CNT) && !encRise |=> napActive && !internalClockValid)
        else $error("nap not entered after encode clock stall");

    chk_lock_gate: assert property ( // RULE_03
        dcsEn && !locked |-> !internalClockValid)
        else $error("internal clock valid before stabilizer lock");

    chk_dcs_strap: assert property ( // RULE_04
        parS |-> dcsEn == csS)
        else $error("stabilizer enable does not follow strap");

    chk_no_par_ddrcmos: assert property ( // RULE_06
        parS |-> mode != MODE_DDR_CMOS)
        else $error("ddr cmos selected in parallel mode");

    chk_ddr_even_half: assert property ( // RULE_10
        (mode != MODE_FULL_CMOS) && iclRise && $stable(mode) |=> pins.chanOneDdrPin
        == {holdOne_r[14], holdOne_r[12], holdOne_r[10], holdOne_r[8], holdOne_r[6],
        holdOne_r[4], holdOne_r[2], holdOne_r[0]})
        else $error("even bits missing in low half");

    chk_shared_flag: assert property ( // RULE_12
        (mode != MODE_FULL_CMOS) && iclFall && $stable(mode) |=> pins.sharedOverrangeOut
        == $past(holdOfOne_r))
        else $error("channel one flag missing in high half");

    chk_term_double: assert property ( // RULE_14
        lvdsTermEnable |-> lvdsDriveCurrent == CUR_W'({LVDS_CUR_TBL[$past(curSel)], 1'b0}))
        else $error("termination current not doubled");

    chk_saturate_high: assert property ( // RULE_22
        (mode == MODE_FULL_CMOS) && iclRise && coreSampleOne.overRange && !twosComp_r
        ##1 (mode == MODE_FULL_CMOS) |-> pins.chanOneData == CODE_ONES && pins.chanOneOverrange)
        else $error("over range not saturated");

    chk_twos_msb: assert property ( // RULE_21
        twosComp_r && iclRise && !coreSampleOne.overRange && !coreSampleOne.underRange
        |=> holdOne_r == ($past(coreSampleOne.code) ^ CODE_MID))
        else $error("two's complement code wrong");

    chk_full_fall: assert property ( // RULE_16
        (mode == MODE_FULL_CMOS) && $stable(mode) && (phaseSel == 2'h0) && !clkInvert
        && $changed(pins.chanOneData) |-> $fell(forwardedClockPos))
        else $error("data change not at forwarded clock fall");

    cov_lock_reached: cover property (dcsEn && $rose(locked));
    cov_ddr_toggle: cover property ((mode == MODE_DDR_LVDS) && iclRise ##[1:16] iclFall);
    cov_nap_exit: cover property ($fell(napActive_r));
endmodule

/* verif/daof_rx_model.sv */
/*
  receiving logic model: rebuilds both channel samples from the output pins.
  assumes clk runs well above the forwarded clock; ddr tells the pin format.
*/
`timescale 1ns/100ps
module daof_rx_model (
    input wire logic clk,
    input wire logic fwdClk,
    input daof_pkg::daof_pins_t pins,
    input wire logic ddr,
    output logic got,
    output logic [31:0] words,
    output logic [1:0] flags
);
    import daof_pkg::*;
    daof_pins_t lowP = '0;
    daof_pins_t highP = '0;
    logic fwdPrev = 1'b0;
    logic [15:0] w1;
    logic [15:0] w2;
    // even bits from the low phase, odd bits from the high phase
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            w1[2*i] = lowP.chanOneDdrPin[i];
            w1[2*i+1] = highP.chanOneDdrPin[i];
            w2[2*i] = lowP.chanTwoDdrPin[i];
            w2[2*i+1] = highP.chanTwoDdrPin[i];
        end
    end
    // low phase is latched up to the rise, one period ends at the fall
    always_ff @(posedge clk)
    begin
        fwdPrev <= fwdClk;
        got <= fwdPrev && !fwdClk;
        if (!fwdClk)
            lowP <= pins;
        else
            highP <= pins;
        if (fwdPrev && !fwdClk)
        begin
            words <= ddr ? {w1, w2} : {lowP.chanOneData, lowP.chanTwoData};
            flags <= ddr ? {highP.sharedOverrangeOut, lowP.sharedOverrangeOut}
                : {lowP.chanOneOverrange, lowP.chanTwoOverrange};
        end
    end
endmodule

/* verif/daof_top_tb_top.sv */
/*
  bench of the output formatter: registers, output modes, lvds current, nap, straps.
  assumes the receiver model daof_rx_model on the output pins.
*/
`timescale 1ns/100ps
module daof_top_tb_top;
    import daof_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic enc = 1'b0;
    logic encOn = 1'b1;
    logic parMode = 1'b0;
    logic sckStrap = 1'b0;
    logic csStrap = 1'b0;
    daof_sample_t s1 = '0;
    daof_sample_t s2 = '0;
    logic [3:0] regAddr = '0;
    logic [7:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] rdData;
    daof_pins_t pins;
    logic fwdPos;
    logic fwdNeg;
    logic lvdsEn;
    logic lvdsTerm;
    logic [9:0] cur;
    logic nap;
    logic icValid;
    logic ddrSel = 1'b0;
    logic rxGot;
    logic [31:0] rxWords;
    logic [1:0] rxFlags;
    int num_errors = 0;
    int checks = 0;
    int curTbl [8] = '{175, 210, 250, 300, 350, 400, 450, 350};
    logic [7:0] d;

    always #20 clk = ~clk;
    // encode clock, 320 ns period, held low while stopped
    always #160 enc = encOn ? ~enc : 1'b0;

    daof_top #(.NAP_CNT_P(50), .LOCK_CNT_P(4)) u_daof_top (.clk(clk), .srst(srst),
        .encodeClockPos(enc), .parallelMode(parMode), .chipSelectStrap(csStrap),
        .serialClockStrap(sckStrap), .coreSampleOne(s1), .coreSampleTwo(s2),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(rdData), .pins(pins), .forwardedClockPos(fwdPos),
        .forwardedClockNeg(fwdNeg), .lvdsEnable(lvdsEn), .lvdsTermEnable(lvdsTerm),
        .lvdsDriveCurrent(cur), .napActive(nap), .internalClockValid(icValid));
    daof_rx_model u_daof_rx_model (.clk(clk), .fwdClk(fwdPos), .pins(pins),
        .ddr(ddrSel), .got(rxGot), .words(rxWords), .flags(rxFlags));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = rdData;
    endtask
    function automatic logic [15:0] expCode(input daof_sample_t s, input logic fmt);
        logic [15:0] c;
        c = s.overRange ? 16'hffff : (s.underRange ? 16'h0000 : s.code);
        return {c[15] ^ fmt, c[14:0]};
    endfunction
    // one sample pair through a mode and format, judged at the receiver
    task automatic runSample(input logic [7:0] om, input logic fmt, input daof_sample_t a,
        input daof_sample_t b);
        wr(ADDR_OUTMODE, om);
        wr(ADDR_FORMAT, {7'h0, fmt});
        s1 <= a;
        s2 <= b;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk);
            for (int n = 0; n < 100 && rxGot !== 1'b1; n++)
                @(posedge clk);
        end
        chk(rxWords, {expCode(a, fmt), expCode(b, fmt)});
        chk(32'(rxFlags), 32'({|a[17:16], |b[17:16]}));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic testRegs();
        rd(ADDR_CLKMODE);
        chk({24'h0, d}, 32'h0);
        rd(ADDR_OUTMODE);
        chk({24'h0, d}, 32'h10);
        rd(ADDR_FORMAT);
        chk({24'h0, d}, 32'h0);
        rd(4'h9);
        chk({24'h0, d}, 32'h0);
        chk({22'h0, cur}, 32'd350);
        $display("regs done");
    endtask
    task automatic testModes();
        runSample(8'h10, 1'b0, {2'b10, 16'h1234}, {2'b01, 16'h5678});
        runSample(8'h10, 1'b1, {2'b00, 16'h8000}, {2'b00, 16'h1234});
        ddrSel <= 1'b1;
        runSample(8'h11, 1'b0, {2'b00, 16'ha5c3}, {2'b10, 16'h0f0f});
        runSample(8'h12, 1'b1, {2'b01, 16'h3333}, {2'b00, 16'h3c5a});
        ddrSel <= 1'b0;
        $display("modes done");
    endtask
    task automatic testCurrent();
        for (int t = 0; t < 2; t++)
        begin
            for (int c = 0; c < 8; c++)
            begin
                wr(ADDR_OUTMODE, {2'b0, t[0], c[2:0], 2'b10});
                @(posedge clk);
                #1 chk({22'h0, cur}, curTbl[c] << t);
                chk({31'h0, lvdsEn}, 32'h1);
                chk({30'h0, lvdsTerm, fwdNeg ^ fwdPos}, {30'h0, t[0], 1'b1});
            end
        end
        $display("current done");
    endtask
    task automatic testNap();
        wr(ADDR_CLKMODE, 8'h01);
        repeat (80) @(posedge clk);
        chk({31'h0, icValid}, 32'h1);
        rd(ADDR_STATUS);
        chk({24'h0, d}, 32'h0e);
        encOn <= 1'b0;
        repeat (70) @(posedge clk);
        chk({30'h0, nap, icValid}, 32'h2);
        encOn <= 1'b1;
        repeat (40) @(posedge clk);
        chk({31'h0, nap}, 32'h0);
        wr(ADDR_CLKMODE, 8'h00);
        $display("nap done");
    endtask
    task automatic testStraps();
        wr(ADDR_OUTMODE, 8'h3c);
        parMode <= 1'b1;
        sckStrap <= 1'b1;
        csStrap <= 1'b1;
        repeat (12) @(posedge clk);
        chk({21'h0, lvdsEn, cur}, {21'h0, 1'b1, 10'd350});
        parMode <= 1'b0;
        sckStrap <= 1'b0;
        csStrap <= 1'b0;
        $display("straps done");
    endtask
    task automatic results();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        testRegs();
        testModes();
        testCurrent();
        testNap();
        testStraps();
        results();
    end
    // watchdog well past the expected run length
    initial
    begin
        #1200000;
        num_errors++;
        results();
    end
endmodule
